// File: bt656_capture_front_end.sv
// Interlaced 4:2:2 video capture front end with timing-code recovery
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "bt656_cfg.svh"

// =============================================================
// Byte buffer, written one byte at a time, read one word at a time
module byte_buffer #(
  parameter int unsigned DEPTH = `LUMA_DEPTH,
  parameter int unsigned AW = `LUMA_AW
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  input wire logic pop,
  output logic [31:0] rd_word,
  output logic [AW-1:0] level
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW-1:0] lvl;
  } buf_state_t;

  buf_state_t b_q;
  buf_state_t b_d;
  logic do_wr;
  logic do_pop;
  logic has_word;

  // Bytes arriving while full are dropped
  assign do_wr = wr_en && (b_q.lvl < AW'(DEPTH));
  assign has_word = b_q.lvl >= AW'(`WORD_BYTES);
  assign do_pop = pop && has_word;
  assign level = b_q.lvl;
  // Oldest byte sits in the low lane
  assign rd_word = has_word ? {b_q.mem[b_q.rp + AW'(3)],
                               b_q.mem[b_q.rp + AW'(2)],
                               b_q.mem[b_q.rp + AW'(1)],
                               b_q.mem[b_q.rp]} : 32'h00000000;

  always_comb begin
    b_d = b_q;
    if (do_wr) begin
      b_d.mem[b_q.wp] = wr_byte;
      b_d.wp = (b_q.wp == AW'(DEPTH - 1)) ? '0 : b_q.wp + AW'(1);
    end
    if (do_pop) begin
      b_d.rp = (b_q.rp == AW'(DEPTH - `WORD_BYTES)) ? '0 :
               b_q.rp + AW'(`WORD_BYTES);
    end
    b_d.lvl = b_q.lvl + AW'(do_wr) -
              (do_pop ? AW'(`WORD_BYTES) : AW'(0));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      b_q <= '0;
    end else if (clk_en) begin
      b_q <= b_d;
    end
  end
endmodule : byte_buffer

// =============================================================
// What this block does
// [RQ1] Status flags: F is field 1/2, V marks field blanking, H 0 start 1 end.
// [RQ2] Protection nibble per F,V,H triple follows the fixed eight-entry code.
// [RQ3] Correct any single-bit error in flags plus protection, detect doubles.
// [RQ4] Uncorrectable timing code sets the sync error status flag.
// [RQ5] Input is two interlaced fields; capture field 1, field 2 or both.
// [RQ6] Each field has its own start/stop window on pixel and line counts.
// [RQ7] Pixel counter steps every second sample, only while capture enabled.
// [RQ8] From vertical start, capture each line from horizontal start to stop.
// [RQ9] Field done when pixel equals horizontal stop on the vertical stop line.
// [RQ10] Storage split: luma 1280 bytes, each chroma 640 bytes.
// [RQ11] Split samples into luma, blue and red streams, scale if asked.
// [RQ12] Each buffer has its own read-only source word for DMA reads.
// [RQ13] Pixels are stored only while the capture block bit is clear.
// [RQ14] Separate luma, blue, red DMA events fire at threshold double words.
// [RQ15] The DMA drains each buffer through its matching source word.
// [RQ16] Chroma transfers are half the luma transfer size.
// [RQ17] Only qualified samples are taken and advance the pixel counter.
// [RQ18] A timing code is seen only after qualified FF, 00, 00.
// [RQ19] A non-zero sample after FF or first 00 restarts the search.
// [RQ20] Unqualified samples inside a preamble leave the search untouched.
// [RQ21] Fourth sample: bit9 one, then F, V, H, then P3 to P0.
// [RQ22] The two lowest data bits are ignored when decoding timing codes.
// [RQ23] After reset the search looks for FF; pixel and line counts clear.
// [RQ24] Start code clears the pixel count; field change clears line count.
module bt656_capture_front_end (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic capture_clock_in,
  input wire logic capture_qualifier,
  input wire bt656_pkg::vid_sample_t video_data,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic luma_dma_event,
  output logic blue_chroma_dma_event,
  output logic red_chroma_dma_event
);
  import bt656_pkg::*;

  // =============================================================
  // State
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] s3;
    logic [11:0] stab;
    logic [3:0] ctl;
    logic [3:0][31:0] win;
    logic [7:0] thr;
    logic [2:0] stat;
    tr_state_t st;
    logic field;
    logic done;
    logic [1:0] phase;
    logic [11:0] pix;
    logic [11:0] line;
    logic [2:0] above;
    logic [2:0] ev;
    logic waiting;
    logic [31:0] rdata;
  } core_state_t;

  core_state_t r_q;
  core_state_t r_d;

  // =============================================================
  // Helpers
  function automatic logic [3:0] fix_flags(input logic [6:0] rx);
    logic [3:0] res;
    logic [31:0] pt;
    res = 4'h8;
    pt = `PROT_TABLE;
    for (int k = 0; k < 8; k++) begin
      if ($countones(rx ^ {3'(k), pt[4*k +: 4]}) <= 1) begin
        res = {1'b0, 3'(k)};
      end
    end
    return res;
  endfunction : fix_flags

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  logic [11:0] agree;
  logic [11:0] stab_n;
  logic smp;
  logic [7:0] d8;
  logic code_in;
  logic [3:0] dec;
  logic blk;
  logic fen;
  logic [31:0] ws;
  logic [31:0] we;
  logic in_win;
  logic active;
  logic store;
  logic y_wr;
  logic cb_wr;
  logic cr_wr;
  logic fin;
  logic req;
  logic take;
  logic [31:0] wmask;
  logic [31:0] y_word;
  logic [31:0] cb_word;
  logic [31:0] cr_word;
  logic [`LUMA_AW-1:0] y_lvl;
  logic [`CHROMA_AW-1:0] cb_lvl;
  logic [`CHROMA_AW-1:0] cr_lvl;
  logic [2:0] above_n;
  logic [31:0] rd_mux;

  // Pins pass three stages; a bit changes once stages two and three agree
  assign agree = ~(r_q.s2 ^ r_q.s3);
  assign stab_n = (agree & r_q.s3) | (~agree & r_q.stab);
  assign smp = stab_n[11] && !r_q.stab[11] && stab_n[10]; // [RQ17]
  assign d8 = stab_n[9:2]; // [RQ22]
  assign code_in = smp && (r_q.st == TR_GOT_00B);
  // Bits F,V,H then P3..P0 of the fourth sample
  assign dec = fix_flags(d8[6:0]); // [RQ21] [RQ3] [RQ2] [RQ1]

  assign blk = r_q.ctl[`CTL_BLOCK];
  assign fen = r_q.field ? r_q.ctl[`CTL_F2_EN] :
               r_q.ctl[`CTL_F1_EN]; // [RQ5]
  assign ws = r_q.field ? r_q.win[2] : r_q.win[0]; // [RQ6]
  assign we = r_q.field ? r_q.win[3] : r_q.win[1]; // [RQ6]
  assign in_win = (r_q.line >= ws[`WIN_Y]) && (r_q.line <= we[`WIN_Y]) &&
                  (r_q.pix >= ws[`WIN_X]) && (r_q.pix <= we[`WIN_X]); // [RQ8]
  assign active = smp && (r_q.st == TR_SEARCH) &&
                  (d8 != `SAMPLE_ONES) && !blk; // [RQ7]
  // Scaling keeps Cb and the first Y of each pixel pair, dropping Cr and the second Y
  assign store = active && in_win && fen && !r_q.done && !blk &&
                 !(r_q.ctl[`CTL_SCALE] && r_q.pix[0]); // [RQ13] [RQ11]
  // Sample order after a start code is Cb, Y, Cr, Y
  assign y_wr = store && r_q.phase[0]; // [RQ11]
  assign cb_wr = store && (r_q.phase == 2'h0); // [RQ11]
  assign cr_wr = store && (r_q.phase == 2'h2); // [RQ11]
  assign fin = active && fen && !r_q.done && (r_q.phase == 2'h3) &&
               (r_q.pix == we[`WIN_X]) && (r_q.line == we[`WIN_Y]); // [RQ9]

  assign req = avs_read || avs_write;
  assign take = req && !r_q.waiting;
  assign wmask = lane_mask(avs_byteenable);

  // =============================================================
  // Sample buffers
  byte_buffer #(.DEPTH(`LUMA_DEPTH), .AW(`LUMA_AW)) luma_buf ( // [RQ10]
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(y_wr),
    .wr_byte(d8),
    .pop(take && avs_read && (avs_address == `REG_LUMA)),
    .rd_word(y_word),
    .level(y_lvl)
  );

  byte_buffer #(.DEPTH(`CHROMA_DEPTH), .AW(`CHROMA_AW)) blue_buf ( // [RQ10]
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(cb_wr),
    .wr_byte(d8),
    .pop(take && avs_read && (avs_address == `REG_BLUE)),
    .rd_word(cb_word),
    .level(cb_lvl)
  );

  byte_buffer #(.DEPTH(`CHROMA_DEPTH), .AW(`CHROMA_AW)) red_buf ( // [RQ10]
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(cr_wr),
    .wr_byte(d8),
    .pop(take && avs_read && (avs_address == `REG_RED)),
    .rd_word(cr_word),
    .level(cr_lvl)
  );

  // Chroma thresholds are half the luma figure
  assign above_n[0] = (r_q.thr != 8'h00) &&
                      (y_lvl >= {r_q.thr, 3'h0}); // [RQ14]
  assign above_n[1] = (r_q.thr != 8'h00) &&
                      (cb_lvl >= {r_q.thr, 2'h0}); // [RQ14] [RQ16]
  assign above_n[2] = (r_q.thr != 8'h00) &&
                      (cr_lvl >= {r_q.thr, 2'h0}); // [RQ14] [RQ16]

  // =============================================================
  // Register read mux
  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `REG_CTL: rd_mux[3:0] = r_q.ctl;
      `REG_WIN1_START: rd_mux = r_q.win[0];
      `REG_WIN1_STOP: rd_mux = r_q.win[1];
      `REG_WIN2_START: rd_mux = r_q.win[2];
      `REG_WIN2_STOP: rd_mux = r_q.win[3];
      `REG_THRESH: rd_mux[7:0] = r_q.thr;
      `REG_STATUS: rd_mux[2:0] = r_q.stat;
      `REG_POSITION: begin
        rd_mux[`WIN_X] = r_q.pix;
        rd_mux[`WIN_Y] = r_q.line;
        rd_mux[`POS_FIELD] = r_q.field;
      end
      `REG_LUMA: rd_mux = y_word; // [RQ12] [RQ15]
      `REG_BLUE: rd_mux = cb_word; // [RQ12] [RQ15]
      `REG_RED: rd_mux = cr_word; // [RQ12] [RQ15]
      default: rd_mux = 32'h00000000;
    endcase
  end

  // =============================================================
  // Next state
  always_comb begin
    r_d = r_q;
    r_d.s1 = {capture_clock_in, capture_qualifier, video_data};
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.stab = stab_n;

    // Bus: waitrequest drops for one cycle, request taken at that edge
    r_d.waiting = !(req && r_q.waiting);
    if (req && r_q.waiting && avs_read) begin
      r_d.rdata = rd_mux;
    end
    if (take && avs_write) begin
      case (avs_address)
        `REG_CTL: begin
          if (avs_byteenable[0]) begin
            r_d.ctl = avs_writedata[3:0];
          end
        end
        `REG_WIN1_START, `REG_WIN1_STOP, `REG_WIN2_START,
        `REG_WIN2_STOP: begin
          r_d.win[2'(avs_address - `REG_WIN1_START)] =
            ((r_q.win[2'(avs_address - `REG_WIN1_START)] & ~wmask) |
             (avs_writedata & wmask)) & `WIN_MASK; // [RQ6]
        end
        `REG_THRESH: begin
          if (avs_byteenable[0]) begin
            r_d.thr = avs_writedata[7:0];
          end
        end
        `REG_STATUS: begin
          if (avs_byteenable[0]) begin
            r_d.stat = r_q.stat & ~avs_writedata[2:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Timing code search, unqualified samples leave it alone
    if (smp) begin // [RQ20]
      case (r_q.st)
        TR_SEARCH: begin
          if (d8 == `SAMPLE_ONES) begin
            r_d.st = TR_GOT_FF; // [RQ18]
          end
        end
        TR_GOT_FF: begin
          r_d.st = (d8 == `SAMPLE_ZERO) ? TR_GOT_00 : TR_SEARCH; // [RQ19]
        end
        TR_GOT_00: begin
          r_d.st = (d8 == `SAMPLE_ZERO) ? TR_GOT_00B : TR_SEARCH; // [RQ19]
        end
        TR_GOT_00B: r_d.st = TR_SEARCH;
        default: r_d.st = TR_SEARCH;
      endcase
    end

    // Status sets come after the software clear so a set wins
    if (code_in && dec[3]) begin
      r_d.stat[`ST_SYNC_ERR] = 1'b1; // [RQ4]
    end
    if (code_in && !dec[3]) begin
      if (dec[2] != r_q.field) begin
        r_d.field = dec[2];
        r_d.line = 12'h000; // [RQ24]
        r_d.done = 1'b0;
      end else if (dec[0]) begin
        r_d.line = r_q.line + 12'h001;
      end
      if (!dec[0]) begin
        r_d.pix = 12'h000; // [RQ24]
        r_d.phase = 2'h0;
      end
    end
    if (active) begin
      r_d.phase = r_q.phase + 2'h1;
      if (r_q.phase[0]) begin
        r_d.pix = r_q.pix + 12'h001; // [RQ7]
      end
    end
    if (fin) begin
      r_d.done = 1'b1; // [RQ9]
      if (r_q.field) begin
        r_d.stat[`ST_F2_DONE] = 1'b1;
      end else begin
        r_d.stat[`ST_F1_DONE] = 1'b1;
      end
    end

    // DMA events pulse as a buffer reaches its threshold
    r_d.above = above_n;
    r_d.ev = above_n & ~r_q.above; // [RQ14]
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_q <= '0; // [RQ23]
      r_q.ctl <= `CTL_RESET;
      r_q.waiting <= 1'b1;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign avs_readdata = r_q.rdata;
  assign avs_waitrequest = r_q.waiting;
  assign luma_dma_event = r_q.ev[0];
  assign blue_chroma_dma_event = r_q.ev[1];
  assign red_chroma_dma_event = r_q.ev[2];

  // =============================================================
  // Assertions
  reset_search_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ23]
    $past(rst) |-> (r_q.st == TR_SEARCH) && (r_q.pix == 12'h000) &&
      (r_q.line == 12'h000))
    else $error("search or counters not cleared after reset");

  sync_error_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
    clk_en && code_in && dec[3] |=> r_q.stat[`ST_SYNC_ERR])
    else $error("uncorrectable code did not set sync error");

  field_change_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ24]
    clk_en && code_in && !dec[3] && (dec[2] != r_q.field) |=>
      (r_q.field == $past(dec[2])) && (r_q.line == 12'h000))
    else $error("field change did not clear line count");

  pream_drop_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ19]
    clk_en && smp && (r_q.st inside {TR_GOT_FF, TR_GOT_00}) &&
      (d8 != `SAMPLE_ZERO) |=> r_q.st == TR_SEARCH)
    else $error("bad preamble sample did not restart search");

  qual_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ20]
    clk_en && !smp |=> $stable(r_q.st) && $stable(r_q.pix))
    else $error("unqualified sample changed search or pixel count");

  pix_step_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
    clk_en && active && r_q.phase[0] |=> r_q.pix == $past(r_q.pix) + 12'h001)
    else $error("pixel count did not step on second sample");

  block_store_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ13]
    r_q.ctl[`CTL_BLOCK] |-> !(y_wr || cb_wr || cr_wr))
    else $error("sample stored while capture blocked");

  luma_event_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ14]
    clk_en && above_n[0] && !r_q.above[0] |=> luma_dma_event)
    else $error("luma threshold reached without event");

  field_done_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
    clk_en && fin |=> r_q.done && (r_q.stat[`ST_F1_DONE] || r_q.stat[`ST_F2_DONE]))
    else $error("window end did not finish field");

  sav_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ24]
    clk_en && code_in && !dec[3] && !dec[0] |=> r_q.pix == 12'h000)
    else $error("start code did not clear pixel count");
endmodule : bt656_capture_front_end

// File: bt656_cfg.svh
// Register map, field positions, reset values and fixed codes of the capture front end
`ifndef BT656_CFG_SVH
`define BT656_CFG_SVH
`define REG_CTL 4'h0
`define REG_WIN1_START 4'h1
`define REG_WIN1_STOP 4'h2
`define REG_WIN2_START 4'h3
`define REG_WIN2_STOP 4'h4
`define REG_THRESH 4'h5
`define REG_STATUS 4'h6
`define REG_POSITION 4'h7
`define REG_LUMA 4'h8
`define REG_BLUE 4'h9
`define REG_RED 4'hA
`define CTL_BLOCK 0
`define CTL_F1_EN 1
`define CTL_F2_EN 2
`define CTL_SCALE 3
`define CTL_RESET 4'h7
`define WIN_MASK 32'h0FFF0FFF
`define WIN_X 11:0
`define WIN_Y 27:16
`define POS_FIELD 31
`define ST_SYNC_ERR 0
`define ST_F1_DONE 1
`define ST_F2_DONE 2
`define SAMPLE_ONES 8'hFF
`define SAMPLE_ZERO 8'h00
`define PROT_TABLE 32'h1CA76BD0
`define LUMA_DEPTH 1280
`define CHROMA_DEPTH 640
`define LUMA_AW 11
`define CHROMA_AW 10
`define WORD_BYTES 4
`endif

// File: bt656_pkg.sv
// Types shared by the capture front end
package bt656_pkg;
  typedef logic [9:0] vid_sample_t;
  typedef enum logic [1:0] {
    TR_SEARCH = 2'h0,
    TR_GOT_FF = 2'h1,
    TR_GOT_00 = 2'h3,
    TR_GOT_00B = 2'h2
  } tr_state_t;
endpackage : bt656_pkg

// File: video_source_model.sv
// Behavioural video source driving the capture link pins
`timescale 1ns/1ps

// =============================================================
// Video source
module video_source_model (
  output logic capture_clock_in,
  output logic capture_qualifier,
  output bt656_pkg::vid_sample_t video_data
);
  import bt656_pkg::*;
  localparam logic [3:0] PROT [8] = '{4'h0, 4'hD, 4'hB, 4'h6,
                                      4'h7, 4'hA, 4'hC, 4'h1};
  initial begin
    capture_clock_in = 1'b0;
    capture_qualifier = 1'b0;
    video_data = 10'h000;
  end
  // Data settles mid low phase, well before the rising clock
  task automatic send(input logic [7:0] b, input logic q,
                      input logic [1:0] lo);
    #20;
    video_data = {b, lo};
    capture_qualifier = q;
    #20;
    capture_clock_in = 1'b1;
    #40;
    capture_clock_in = 1'b0;
  endtask : send
  // Between lines and timing codes the clock stands low and the data lines wander
  task automatic idle();
    video_data = ~video_data;
    capture_qualifier = 1'b0;
    #100;
  endtask : idle
  // Preamble, then 1,F,V,H,P3..P0 with optional bit flips
  task automatic code(input logic [2:0] fvh, input logic [6:0] flip,
                      input logic gap, input logic [1:0] lo);
    send(8'hFF, 1'b1, lo);
    if (gap) begin
      send(8'h55, 1'b0, lo);
    end
    send(8'h00, 1'b1, lo);
    send(8'h00, 1'b1, lo);
    send({1'b1, {fvh, PROT[fvh]} ^ flip}, 1'b1, lo);
  endtask : code
endmodule : video_source_model

// File: bt656_capture_front_end_test.sv
// Self-checking bench for the capture front end
`timescale 1ns/1ps
`include "bt656_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end

// =============================================================
// Bench top
module bt656_capture_front_end_test;
  import bt656_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] POS = 32'h8FFF0000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic capture_clock_in;
  logic capture_qualifier;
  vid_sample_t video_data;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ev_luma, ev_blue, ev_red;
  int error_cnt = 0;
  int cmp_count = 0;
  int ev_cnt [3] = '{0, 0, 0};
  int seed = 32'h4CA33D46;
  int p;
  logic f_exp = 1'b0;
  logic [11:0] l_exp = 12'h0;
  logic [7:0] yq [$], cbq [$], crq [$];

  bt656_capture_front_end bt656_capture_front_end_i (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .capture_clock_in(capture_clock_in),
    .capture_qualifier(capture_qualifier), .video_data(video_data),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .luma_dma_event(ev_luma),
    .blue_chroma_dma_event(ev_blue), .red_chroma_dma_event(ev_red)
  );
  video_source_model video_source_model_i (
    .capture_clock_in(capture_clock_in),
    .capture_qualifier(capture_qualifier), .video_data(video_data)
  );

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (ev_luma === 1'b1) ev_cnt[0]++;
    if (ev_blue === 1'b1) ev_cnt[1]++;
    if (ev_red === 1'b1) ev_cnt[2]++;
  end

  // =============================================================
  // Bus and stream helpers
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] v);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Only the watchdog ends a wait that never sees the answer
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    `CHK(avs_waitrequest, 1'b0)
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, 4'hF, v);
    `CHK(v & m, e)
  endtask : rdc
  task automatic wrr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    logic [31:0] v;
    bus(1'b1, a, d, be, v);
  endtask : wrr
  // Random pixel bytes with stray unqualified samples between them
  task automatic line(input int n, input logic keep);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'(($random(seed) & 32'h7F) + 1);
      if ($random(seed) & 1) video_source_model_i.send(8'h55, 1'b0, 2'h0);
      video_source_model_i.send(b, 1'b1, 2'(i));
      if (keep && i < 16) begin
        case (i % 4)
          0: cbq.push_back(b);
          2: crq.push_back(b);
          default: yq.push_back(b);
        endcase
      end
    end
    video_source_model_i.idle();
  endtask : line
  // Timing code with tracking of expected field and line
  task automatic tcode(input logic [2:0] fvh, input logic [6:0] flip);
    video_source_model_i.code(fvh, flip, 1'($random(seed)),
                              2'($random(seed)));
    video_source_model_i.idle();
    if (fvh[2] != f_exp) begin
      f_exp = fvh[2];
      l_exp = 12'h0;
    end else if (fvh[0]) begin
      l_exp++;
    end
  endtask : tcode
  function automatic logic [31:0] w4(input logic [7:0] q [$], input int k);
    return {q[k + 3], q[k + 2], q[k + 1], q[k]};
  endfunction : w4
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  // =============================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(`REG_CTL, 32'h7, ALL);
    rdc(`REG_POSITION, 32'h0, ALL);
    rdc(`REG_STATUS, 32'h0, ALL);
    wrr(4'hB, ALL, 4'hF);
    rdc(4'hB, 32'h0, ALL);
    end_test("reset");
    wrr(`REG_WIN1_STOP, ALL, 4'hF);
    wrr(`REG_WIN1_STOP, 32'h00000007, 4'h3);
    rdc(`REG_WIN1_STOP, 32'h0FFF0007, ALL);
    wrr(`REG_WIN1_STOP, 32'h00000007, 4'hF);
    wrr(`REG_WIN1_START, 32'h0, 4'hF);
    wrr(`REG_WIN2_START, 32'h0, 4'hF);
    wrr(`REG_WIN2_STOP, 32'h00000007, 4'hF);
    wrr(`REG_THRESH, 32'h1, 4'hF);
    end_test("window");
    tcode(3'b000, 7'h0);
    line(20, 1'b0);
    rdc(`REG_LUMA, 32'h0, ALL);
    end_test("blocked");
    wrr(`REG_CTL, 32'h2, 4'hF);
    tcode(3'b100, 7'h0);
    line(20, 1'b0);
    rdc(`REG_LUMA, 32'h0, ALL);
    tcode(3'b000, 7'h0);
    line(20, 1'b1);
    rdc(`REG_STATUS, 32'h2, 32'h2);
    `CHK(ev_cnt[0], 1)
    `CHK(ev_cnt[1], 1)
    `CHK(ev_cnt[2], 1)
    rdc(`REG_LUMA, w4(yq, 0), ALL);
    rdc(`REG_LUMA, w4(yq, 4), ALL);
    rdc(`REG_BLUE, w4(cbq, 0), ALL);
    rdc(`REG_RED, w4(crq, 0), ALL);
    rdc(`REG_LUMA, 32'h0, ALL);
    end_test("capture");
    for (int i = 0; i < 8; i++) begin
      tcode(3'(i), 7'h1 << ($unsigned($random(seed)) % 7));
      rdc(`REG_POSITION, {f_exp, 3'h0, l_exp, 16'h0}, POS);
      rdc(`REG_STATUS, 32'h0, 32'h1);
    end
    p = $unsigned($random(seed)) % 7;
    video_source_model_i.code(3'b001, (7'h1 << p) | (7'h1 << ((p + 1) % 7)),
                              1'b0, 2'h3);
    video_source_model_i.idle();
    rdc(`REG_STATUS, 32'h1, 32'h1);
    rdc(`REG_POSITION, {f_exp, 3'h0, l_exp, 16'h0}, POS);
    wrr(`REG_STATUS, 32'h1, 4'hF);
    rdc(`REG_STATUS, 32'h0, 32'h1);
    end_test("codes");
    for (int k = 1; k <= 2; k++) begin
      video_source_model_i.send(8'hFF, 1'b1, 2'h0);
      if (k == 2) video_source_model_i.send(8'h00, 1'b1, 2'h0);
      video_source_model_i.send(8'h05, 1'b1, 2'h0);
      video_source_model_i.send(8'h00, 1'b1, 2'h0);
      video_source_model_i.send(8'h00, 1'b1, 2'h0);
      video_source_model_i.send({1'b1, f_exp, 2'b01, 4'hD}, 1'b1, 2'h0);
      video_source_model_i.idle();
      rdc(`REG_POSITION, {f_exp, 3'h0, l_exp, 16'h0}, POS);
    end
    tcode({f_exp, 2'b01}, 7'h0);
    rdc(`REG_POSITION, {f_exp, 3'h0, l_exp, 16'h0}, POS);
    end_test("preamble");
    final_report();
  end
endmodule : bt656_capture_front_end_test
